// ---- rsq_params.svh ----
// constants of the reset and interrupt sequencer
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH
`define RSQ_CLK_DIV       4
`define RSQ_CTRL_ADDR     8'h14
`define RSQ_STAT_ADDR     8'h30
`define RSQ_CTRL_RESET    8'h48
`define RSQ_BIT_EXT_INT_REQ_ONE_EN   0
`define RSQ_BIT_EXT_INT_REQ_TWO_EN   1
`define RSQ_BIT_RAM_EN    6
`define RSQ_RST_ADDR_CYC  3
`define RSQ_POR_MS        20
`define RSQ_STACK_CYC     7
`define RSQ_VEC_RESET     16'hfffe
`define RSQ_VEC_FAULT     16'hffee
`define RSQ_VEC_NMI       16'hfffc
`define RSQ_VEC_SOFT      16'hfffa
`define RSQ_VEC_EXT1      16'hfff8
`define RSQ_VEC_CAPT      16'hfff6
`define RSQ_VEC_COMP      16'hfff4
`define RSQ_VEC_OVFL      16'hfff2
`define RSQ_VEC_TMR2      16'hffec
`define RSQ_VEC_EXT2      16'hffea
`define RSQ_VEC_SER       16'hfff0
`define RSQ_SRC_MASKABLE  4'h3
`endif

// ---- rsq_pkg.sv ----
// types of the reset and interrupt sequencer
package rsq_pkg;

  typedef enum logic [2:0] {
    S_RUN   = 3'h0,
    S_HOLD  = 3'h1,
    S_LATCH = 3'h2,
    S_INIT  = 3'h3,
    S_MASK  = 3'h4,
    S_VECT  = 3'h5,
    S_STACK = 3'h6,
    S_IVEC  = 3'h7
  } rsq_st_type;

  typedef struct packed {
    logic strobe_flag_int;
    logic capture_int;
    logic compare_int;
    logic overflow_int;
    logic timer2_match_int;
    logic serial_int;
  } rsq_periph_type;

  typedef struct packed {
    rsq_st_type  st;
    logic [1:0]  div;
    logic        bus_clk;
    logic [1:0]  rst_cnt;
    logic        addr_high;
    logic        osc_stop;
    logic        core_reset;
    logic [1:0]  mode;
    logic        mask;
    logic [7:0]  ctrl;
    logic        nmi_prev;
    logic        nmi_pend;
    logic [2:0]  stk_cnt;
    logic [3:0]  src;
    logic [15:0] vec;
    logic        vec_load;
    logic        stack_act;
    logic        merged;
    logic [7:0]  rdata;
  } rsq_regs_type;

endpackage

// ---- rsq_sequencer.sv ----
// reset, standby and interrupt sequencer
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "rsq_params.svh"

module rsq_sequencer (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    standby_request_n,
  input  wire logic                    power_on_clear_n,
  input  wire logic                    mode_select_a,
  input  wire logic                    mode_select_b,
  input  wire logic                    nmi_n,
  input  wire logic                    ext_int_req_one_n,
  input  wire logic                    ext_int_req_two_n,
  input  wire rsq_pkg::rsq_periph_type periph,
  input  wire logic                    soft_int,
  input  wire logic                    fault_int,
  input  wire logic                    instr_done,
  input  wire logic                    cc_mask_set,
  input  wire logic                    cc_mask_clear,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  output logic                         bus_clock,
  output logic                         osc_stop,
  output logic                         core_reset,
  output logic                         addr_all_high,
  output logic [1:0]                   mode_latched,
  output logic                         int_mask,
  output logic                         ram_enable,
  output logic                         merged_internal_req,
  output logic                         stack_active,
  output logic                         vector_load,
  output logic [15:0]                  vector_addr
);

  // ------------------------------------------------------------
  // state and request decode
  // ------------------------------------------------------------
  rsq_pkg::rsq_regs_type q;
  rsq_pkg::rsq_regs_type d;
  logic                  sys_en;
  logic                  nmi_fall;
  logic [9:0]            req;
  logic                  any_req;
  logic [3:0]            pick;

  assign sys_en   = (q.div == 2'h3);
  assign nmi_fall = q.nmi_prev & ~nmi_n;

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    case (s)
      4'h0:    vec_of = `RSQ_VEC_FAULT;
      4'h1:    vec_of = `RSQ_VEC_NMI;
      4'h2:    vec_of = `RSQ_VEC_SOFT;
      4'h3:    vec_of = `RSQ_VEC_EXT1;
      4'h4:    vec_of = `RSQ_VEC_CAPT;
      4'h5:    vec_of = `RSQ_VEC_COMP;
      4'h6:    vec_of = `RSQ_VEC_OVFL;
      4'h7:    vec_of = `RSQ_VEC_TMR2;
      4'h8:    vec_of = `RSQ_VEC_EXT2;
      default: vec_of = `RSQ_VEC_SER;
    endcase
  endfunction

  // ------------------------------------------------------------
  // request vector and priority
  // ------------------------------------------------------------
  always_comb begin
    req[0] = fault_int;
    req[1] = q.nmi_pend;
    req[2] = soft_int;
    req[3] = ~q.mask & ((~ext_int_req_one_n & q.ctrl[`RSQ_BIT_EXT_INT_REQ_ONE_EN])
                        | periph.strobe_flag_int);
    req[4] = ~q.mask & periph.capture_int;
    req[5] = ~q.mask & periph.compare_int;
    req[6] = ~q.mask & periph.overflow_int;
    req[7] = ~q.mask & periph.timer2_match_int;
    req[8] = ~q.mask & ~ext_int_req_two_n & q.ctrl[`RSQ_BIT_EXT_INT_REQ_TWO_EN];
    req[9] = ~q.mask & periph.serial_int;
    any_req = |req;
    pick = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (req[i]) begin
        pick = 4'(i);
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.vec_load = 1'b0;
    d.div = q.div + 2'h1;
    d.bus_clk = d.div[1];
    d.nmi_prev = nmi_n;
    d.merged = periph.capture_int | periph.compare_int | periph.overflow_int
               | periph.timer2_match_int | periph.serial_int;
    d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RSQ_CTRL_ADDR: d.rdata = q.ctrl;
        `RSQ_STAT_ADDR: d.rdata = {q.core_reset, q.mask, q.mode, q.nmi_pend,
                                   q.merged, q.addr_high, q.stack_act};
        default:        d.rdata = 8'h00;
      endcase
    end
    if (reg_wr && reg_addr == `RSQ_CTRL_ADDR) begin
      d.ctrl = reg_wdata;
    end
    if (cc_mask_clear) begin
      d.mask = 1'b0;
    end
    if (cc_mask_set) begin
      d.mask = 1'b1;
    end
    unique case (q.st)
      rsq_pkg::S_RUN: begin
        if (instr_done && any_req) begin
          d.st = rsq_pkg::S_STACK;
          d.src = pick;
          d.stack_act = 1'b1;
          d.stk_cnt = 3'h0;
          if (pick == 4'h1) begin
            d.nmi_pend = 1'b0;
          end
        end
      end
      rsq_pkg::S_STACK: begin
        if (sys_en) begin
          if (q.stk_cnt == 3'(`RSQ_STACK_CYC - 1)) begin
            d.st = rsq_pkg::S_IVEC;
          end else begin
            d.stk_cnt = q.stk_cnt + 3'h1;
          end
        end
      end
      rsq_pkg::S_IVEC: begin
        if (sys_en) begin
          d.vec = vec_of(q.src);
          d.vec_load = 1'b1;
          d.stack_act = 1'b0;
          if (q.src >= `RSQ_SRC_MASKABLE) begin
            d.mask = 1'b1;
          end
          d.st = rsq_pkg::S_RUN;
        end
      end
      rsq_pkg::S_HOLD: begin
        if (sys_en) begin
          d.st = rsq_pkg::S_LATCH;
        end
      end
      rsq_pkg::S_LATCH: begin
        if (sys_en) begin
          d.mode = {mode_select_b, mode_select_a};
          d.addr_high = 1'b0;
          d.rst_cnt = 2'h0;
          d.st = rsq_pkg::S_INIT;
        end
      end
      rsq_pkg::S_INIT: begin
        if (sys_en) begin
          d.ctrl = `RSQ_CTRL_RESET;
          d.nmi_pend = 1'b0;
          d.st = rsq_pkg::S_MASK;
        end
      end
      rsq_pkg::S_MASK: begin
        if (sys_en) begin
          d.mask = 1'b1;
          d.st = rsq_pkg::S_VECT;
        end
      end
      rsq_pkg::S_VECT: begin
        if (sys_en) begin
          d.vec = `RSQ_VEC_RESET;
          d.vec_load = 1'b1;
          d.core_reset = 1'b0;
          d.st = rsq_pkg::S_RUN;
        end
      end
    endcase
    // set wins over the clear on acceptance
    if (nmi_fall) begin
      d.nmi_pend = 1'b1;
    end
    // cpu registers, ram and port data are outside this state
    if (!power_on_clear_n || !standby_request_n) begin
      d.st = rsq_pkg::S_HOLD;
      d.core_reset = 1'b1;
      d.stack_act = 1'b0;
      d.osc_stop = ~standby_request_n;
      if (sys_en && !power_on_clear_n) begin
        if (q.rst_cnt == 2'(`RSQ_RST_ADDR_CYC - 1)) begin
          d.addr_high = 1'b1;
        end else begin
          d.rst_cnt = q.rst_cnt + 2'h1;
        end
      end
    end else begin
      d.osc_stop = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: rsq_pkg::S_HOLD, core_reset: 1'b1, mask: 1'b1,
             ctrl: `RSQ_CTRL_RESET, nmi_prev: 1'b1, vec: `RSQ_VEC_RESET,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign reg_rdata           = q.rdata;
  assign bus_clock           = q.bus_clk;
  assign osc_stop            = q.osc_stop;
  assign core_reset          = q.core_reset;
  assign addr_all_high       = q.addr_high;
  assign mode_latched        = q.mode;
  assign int_mask            = q.mask;
  assign ram_enable          = q.ctrl[`RSQ_BIT_RAM_EN];
  assign merged_internal_req = q.merged;
  assign stack_active        = q.stack_act;
  assign vector_load         = q.vec_load;
  assign vector_addr         = q.vec;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_bus_clk;
    $rose(q.bus_clk) |-> ##4 $rose(q.bus_clk);
  endproperty
  a_bus_clk: assert property (p_bus_clk) else $error("bus clock not div by four");

  property p_standby;
    !standby_request_n |=> q.osc_stop && q.core_reset && q.st == rsq_pkg::S_HOLD;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not holding reset");

  property p_ram_en;
    reg_wr && reg_addr == `RSQ_CTRL_ADDR && q.st != rsq_pkg::S_INIT
      |=> ram_enable == $past(reg_wdata[`RSQ_BIT_RAM_EN]);
  endproperty
  a_ram_en: assert property (p_ram_en) else $error("ram enable not written");

  property p_addr_high;
    !power_on_clear_n && sys_en && q.rst_cnt == 2'h2 |=> q.addr_high [*3];
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("address lines not high");

  property p_reset_seq;
    q.st == rsq_pkg::S_LATCH && sys_en && power_on_clear_n && standby_request_n
      |=> q.mode == $past({mode_select_b, mode_select_a}) ##8 q.mask
      ##4 (q.vec_load && q.vec == `RSQ_VEC_RESET && q.mask);
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence wrong");

  property p_nmi_pend;
    nmi_fall |=> q.nmi_pend;
  endproperty
  a_nmi_pend: assert property (p_nmi_pend) else $error("nmi edge lost");

  property p_nmi_unmasked;
    q.st == rsq_pkg::S_RUN && q.nmi_pend && q.mask && instr_done && !fault_int
      && power_on_clear_n && standby_request_n |=> q.st == rsq_pkg::S_STACK && q.src == 4'h1;
  endproperty
  a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi blocked by mask");

  property p_masked;
    q.st == rsq_pkg::S_RUN && q.mask && !q.nmi_pend && !fault_int && !soft_int
      && power_on_clear_n && standby_request_n |=> q.st == rsq_pkg::S_RUN;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken");

  property p_mask_after;
    q.st == rsq_pkg::S_IVEC && sys_en && q.src >= `RSQ_SRC_MASKABLE
      && power_on_clear_n && standby_request_n && !cc_mask_clear |=> q.mask && q.vec_load;
  endproperty
  a_mask_after: assert property (p_mask_after) else $error("mask not set");

  property p_vec_fetch;
    q.st == rsq_pkg::S_STACK && q.stk_cnt == 3'h6 && sys_en && power_on_clear_n
      && standby_request_n |-> ##5 q.vec_load && q.vec == vec_of($past(q.src, 5));
  endproperty
  a_vec_fetch: assert property (p_vec_fetch) else $error("wrong vector fetched");

  property p_priority;
    q.st == rsq_pkg::S_RUN && instr_done && fault_int && power_on_clear_n
      && standby_request_n |=> q.src == 4'h0;
  endproperty
  a_priority: assert property (p_priority) else $error("priority wrong");

  property p_ctrl_init;
    q.st == rsq_pkg::S_INIT && sys_en |=> q.ctrl == `RSQ_CTRL_RESET;
  endproperty
  a_ctrl_init: assert property (p_ctrl_init) else $error("control not reinitialised");

  property p_osc_run;
    standby_request_n |=> !q.osc_stop;
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator stopped without standby");

  property p_ext_int_req_two_gate;
    q.st == rsq_pkg::S_RUN && instr_done && !q.ctrl[`RSQ_BIT_EXT_INT_REQ_TWO_EN] && !ext_int_req_two_n
      && ext_int_req_one_n && periph == '0 && !q.nmi_pend && !fault_int && !soft_int
      && power_on_clear_n && standby_request_n |=> q.st == rsq_pkg::S_RUN;
  endproperty
  a_ext_int_req_two_gate: assert property (p_ext_int_req_two_gate) else $error("disabled request pin taken");

  property p_merged;
    periph.capture_int || periph.compare_int || periph.overflow_int
      || periph.timer2_match_int || periph.serial_int |=> q.merged;
  endproperty
  a_merged: assert property (p_merged) else $error("internal request not merged");

  property p_vec_once;
    q.vec_load |=> !q.vec_load;
  endproperty
  a_vec_once: assert property (p_vec_once) else $error("vector load longer than one cycle");

  property p_ctrl_read;
    reg_rd && reg_addr == `RSQ_CTRL_ADDR |=> q.rdata == $past(q.ctrl);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");

  property p_rdata_idle;
    !reg_rd |=> q.rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  c_reset: cover property (q.st == rsq_pkg::S_VECT ##[1:8] q.vec_load);
  c_nmi:   cover property (q.st == rsq_pkg::S_IVEC && q.src == 4'h1);
  c_ext2:  cover property (q.st == rsq_pkg::S_IVEC && q.src == 4'h8);
  c_rrst:  cover property (q.addr_high ##1 !q.addr_high);

endmodule // rsq_sequencer

// ---- rsq_source_model.sv ----
// far-side model: reset circuit and interrupt request pins
`timescale 1ns/10ps

module rsq_source_model #(
  parameter int RST_CLKS = 20
) (
  input  wire logic clock,
  input  wire logic rst_go,
  input  wire logic nmi_go,
  input  wire logic irq_one,
  input  wire logic irq_two,
  output logic      power_on_clear_n,
  output logic      nmi_n,
  output logic      ext_int_req_one_n,
  output logic      ext_int_req_two_n
);
  int rst_cnt = 0;
  int nmi_cnt = 0;

  // reset low for 5 system cycles; power-on hold shortened
  always @(posedge clock) begin
    if (rst_go) begin
      rst_cnt <= RST_CLKS;
    end else if (rst_cnt > 0) begin
      rst_cnt <= rst_cnt - 1;
    end
    if (nmi_go) begin
      nmi_cnt <= 4;
    end else if (nmi_cnt > 0) begin
      nmi_cnt <= nmi_cnt - 1;
    end
  end

  assign power_on_clear_n  = (rst_cnt == 0);
  assign nmi_n             = (nmi_cnt == 0);
  assign ext_int_req_one_n = !irq_one;
  assign ext_int_req_two_n = !irq_two;
endmodule // rsq_source_model

// ---- tb_top.sv ----
// self-checking bench of the reset and interrupt sequencer
`timescale 1ns/10ps

module tb_top;
  logic clock = 0, rst_n = 0, standby_request_n = 1;
  logic rst_go = 0, nmi_go = 0, irq_one = 0, irq_two = 0;
  logic soft_int = 0, fault_int = 0, instr_done = 0, cc_mask_set = 0, cc_mask_clear = 0;
  logic reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  rsq_pkg::rsq_periph_type periph = '0;
  logic power_on_clear_n, nmi_n, ext_int_req_one_n, ext_int_req_two_n;
  logic bus_clock, osc_stop, core_reset, addr_all_high, int_mask, ram_enable;
  logic merged_internal_req, stack_active, vector_load;
  logic [1:0] mode_latched;
  logic [15:0] vector_addr;
  int n_errors = 0, compares = 0, cyc = 0;
  logic [15:0] vt [6] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffec, 16'hfff0};

  always #2 clock = ~clock;

  rsq_source_model src_u (.clock(clock), .rst_go(rst_go), .nmi_go(nmi_go), .irq_one(irq_one),
    .irq_two(irq_two), .power_on_clear_n(power_on_clear_n), .nmi_n(nmi_n),
    .ext_int_req_one_n(ext_int_req_one_n), .ext_int_req_two_n(ext_int_req_two_n));

  rsq_sequencer dut_u (.clock(clock), .rst_n(rst_n), .standby_request_n(standby_request_n),
    .power_on_clear_n(power_on_clear_n), .mode_select_a(1'b1), .mode_select_b(1'b0),
    .nmi_n(nmi_n), .ext_int_req_one_n(ext_int_req_one_n), .ext_int_req_two_n(ext_int_req_two_n),
    .periph(periph), .soft_int(soft_int), .fault_int(fault_int), .instr_done(instr_done),
    .cc_mask_set(cc_mask_set), .cc_mask_clear(cc_mask_clear), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_clock(bus_clock), .osc_stop(osc_stop), .core_reset(core_reset),
    .addr_all_high(addr_all_high), .mode_latched(mode_latched), .int_mask(int_mask),
    .ram_enable(ram_enable), .merged_internal_req(merged_internal_req),
    .stack_active(stack_active), .vector_load(vector_load), .vector_addr(vector_addr));

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // wait for the vector pulse, then compare the vector
  task automatic wait_vec(input string nm, input logic [15:0] e);
    int i;
    for (i = 0; i < 80 && vector_load !== 1'b1; i++) @(negedge clock);
    chk("vector_load", 1'b1, vector_load);
    chk(nm, e, vector_addr);
    @(posedge clock);
  endtask

  // optional mask clear, one instruction boundary, then the vector
  task automatic take(input string nm, input logic clr, input logic [15:0] e);
    @(posedge clock);
    cc_mask_clear <= clr;
    @(posedge clock);
    cc_mask_clear <= 1'b0; instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
    wait_vec(nm, e);
  endtask

  task automatic t_reset();
    wait_vec("reset vector", 16'hfffe);
    chk("mask", 1'b1, int_mask);
    chk("mode", 2'b01, mode_latched);
    chk("core_reset", 1'b0, core_reset);
    rd(8'h14, rv);
    chk("ctrl reset", 8'h48, rv);
    rd(8'h30, rv);
    chk("status", 8'h50, rv);
    $display("test reset done");
  endtask

  task automatic t_clkdiv();
    int hi = 0, rise = 0;
    logic p;
    @(negedge clock);
    p = bus_clock;
    repeat (16) begin
      @(negedge clock);
      hi += bus_clock;
      rise += (bus_clock && !p);
      p = bus_clock;
    end
    chk("bus_clock high", 16'd8, 16'(hi));
    chk("bus_clock rises", 16'd4, 16'(rise));
    $display("test clkdiv done");
  endtask

  task automatic t_runreset();
    wr(8'h14, 8'h00);
    @(posedge clock);
    rst_go <= 1'b1;
    @(posedge clock);
    rst_go <= 1'b0;
    repeat (17) @(negedge clock);
    chk("addr high", 1'b1, addr_all_high);
    wait_vec("run reset vector", 16'hfffe);
    rd(8'h14, rv);
    chk("ctrl reinit", 8'h48, rv);
    $display("test runreset done");
  endtask

  task automatic t_regs();
    wr(8'h14, 8'h03);
    @(negedge clock);
    chk("ram off", 1'b0, ram_enable);
    rd(8'h14, rv);
    chk("ctrl rb", 8'h03, rv);
    rd(8'h55, rv);
    chk("unmapped", 8'h00, rv);
    $display("test regs done");
  endtask

  task automatic t_irq();
    @(posedge clock);
    nmi_go <= 1'b1;
    @(posedge clock);
    nmi_go <= 1'b0;
    repeat (3) @(posedge clock);
    take("nmi masked", 1'b0, 16'hfffc);
    irq_one <= 1'b1;
    take("ext_int_req_one", 1'b1, 16'hfff8);
    chk("mask after", 1'b1, int_mask);
    instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
    repeat (3) @(negedge clock);
    chk("masked refused", 1'b0, stack_active);
    irq_one <= 1'b0;
    wr(8'h14, 8'h00);
    irq_two <= 1'b1;
    cc_mask_clear <= 1'b1;
    @(posedge clock);
    cc_mask_clear <= 1'b0;
    instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
    repeat (3) @(negedge clock);
    chk("ext_int_req_two disabled", 1'b0, stack_active);
    chk("mask clear", 1'b0, int_mask);
    irq_two <= 1'b0;
    wr(8'h14, 8'h03);
    $display("test irq done");
  endtask

  task automatic t_table();
    for (int i = 0; i < 6; i++) begin
      periph <= rsq_pkg::rsq_periph_type'(6'h20 >> i);
      take("periph vector", 1'b1, vt[i]);
      chk("merged", i > 0, merged_internal_req);
    end
    periph <= '0;
    $display("test table done");
  endtask

  task automatic t_prio();
    periph <= rsq_pkg::rsq_periph_type'(6'h10);
    irq_two <= 1'b1;
    take("capt over ext_int_req_two", 1'b1, 16'hfff6);
    periph <= '0;
    take("ext_int_req_two pending", 1'b1, 16'hffea);
    irq_two <= 1'b0;
    fault_int <= 1'b1; soft_int <= 1'b1; nmi_go <= 1'b1;
    @(posedge clock);
    nmi_go <= 1'b0;
    repeat (3) @(posedge clock);
    take("fault first", 1'b0, 16'hffee);
    fault_int <= 1'b0;
    take("nmi next", 1'b0, 16'hfffc);
    take("soft last", 1'b0, 16'hfffa);
    soft_int <= 1'b0;
    $display("test prio done");
  endtask

  task automatic t_standby();
    @(posedge clock);
    standby_request_n <= 1'b0;
    repeat (3) @(negedge clock);
    chk("osc_stop", 1'b1, osc_stop);
    chk("held reset", 1'b1, core_reset);
    @(posedge clock);
    standby_request_n <= 1'b1;
    wait_vec("standby vector", 16'hfffe);
    $display("test standby done");
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_clkdiv();
    t_runreset();
    t_regs();
    t_irq();
    t_table();
    t_prio();
    t_standby();
    test_done();
  end
endmodule // tb_top
